//--- src/lcf_pkg.sv
// constants, types and helpers of the link core control flag bank
// Behaviour
// RULE_01: reserved flag-word bits always read zero
// RULE_02: flag word at set and clear offsets
// RULE_03: ones set or clear, zeros keep, reads return flags
// RULE_04: select set: external input rolls timer over
// RULE_05: select clear: roll over after 3072 ticks
// RULE_06: originator and root: cycle start every rollover
// RULE_07: originator clear: received cycle starts resynchronise timer
// RULE_08: overlong event clears originator enable
// RULE_09: originator set ignored while overlong event stands
// RULE_10: run set: offset advances each tick
// RULE_11: run clear: offset holds still
// RULE_12: phy packets accepted when flag and context enabled
// RULE_13: phy flag never gates self-id reception
// RULE_14: self-id flag set: self-id packets accepted
// RULE_15: host loads self-id buffer pointer before enabling
// RULE_16: root status recorded during bus reset
package lcf_pkg;
	localparam logic [7:0] SET_OFFSET = 8'hE0;
	localparam logic [7:0] CLR_OFFSET = 8'hE4;
	localparam logic [7:0] STAT_OFFSET = 8'hF0;
	localparam int ORIGIN_SEL_BIT = 22;
	localparam int ORIGINATOR_BIT = 21;
	localparam int RUN_BIT = 20;
	localparam int PHY_PKT_BIT = 10;
	localparam int SELFID_BIT = 9;
	localparam int STAT_ROOT_BIT = 30;
	localparam int STAT_OVERLONG_BIT = 25;
	localparam logic [31:0] FLAG_MASK = 32'h0070_0600;
	localparam logic [31:0] FLAG_RESET = 32'h0000_0000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int CLK_HZ = 200000000;
	localparam int TICK_HZ = 24576000;
	localparam int NCO_GCD = 8000;
	localparam logic [15:0] NCO_STEP = 16'(TICK_HZ / NCO_GCD);
	localparam logic [15:0] NCO_MOD = 16'(CLK_HZ / NCO_GCD);
	localparam int CYCLE_TICKS = 3072;
	localparam logic [11:0] OFFSET_LAST = 12'(CYCLE_TICKS - 1);
	localparam logic [11:0] OFFSET_MAX = 12'hFFF;

	typedef enum logic [1:0] {WR_IDLE = 2'b01, WR_RESP = 2'b10} lcf_wr_state_type;
	typedef enum logic [1:0] {RD_IDLE = 2'b01, RD_DATA = 2'b10} lcf_rd_state_type;
	typedef enum logic [3:0] {
		SEL_SET = 4'b0001, SEL_CLR = 4'b0010, SEL_STAT = 4'b0100, SEL_NONE = 4'b1000
	} lcf_sel_type;

	typedef struct packed {
		logic run;
		logic ext_select;
		logic resync;
	} lcf_timer_ctl_type;

	typedef struct packed {
		logic rollover;
		logic [11:0] offset;
	} lcf_timer_stat_type;

	typedef struct packed {
		logic [14:0] nco;
		logic [11:0] offset;
		logic rollover;
		logic ext_prev;
	} lcf_timer_state_type;

	localparam lcf_timer_state_type TIMER_RESET = '{15'h0000, 12'h000, 1'b0, 1'b0};

	typedef struct packed {
		lcf_wr_state_type wst;
		lcf_rd_state_type rst;
		logic aw_got;
		logic w_got;
		logic [7:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [31:0] flags;
		logic root;
		logic cycle_start;
		logic phy_accept;
		logic selfid_accept;
	} lcf_bank_state_type;

	localparam lcf_bank_state_type BANK_RESET = '{WR_IDLE, RD_IDLE, 1'b0, 1'b0, 8'h00,
		32'h0000_0000, 4'h0, 1'b1, 1'b1, 1'b0, RESP_OKAY, 1'b1, 1'b0, 32'h0000_0000,
		RESP_OKAY, FLAG_RESET, 1'b0, 1'b0, 1'b0, 1'b0};

	function automatic lcf_sel_type lcf_decode(input logic [7:0] addr);
		lcf_sel_type sel;
		if (addr[7:2] == SET_OFFSET[7:2]) begin
			sel = SEL_SET;
		end else if (addr[7:2] == CLR_OFFSET[7:2]) begin
			sel = SEL_CLR;
		end else if (addr[7:2] == STAT_OFFSET[7:2]) begin
			sel = SEL_STAT;
		end else begin
			sel = SEL_NONE;
		end
		return sel;
	endfunction : lcf_decode

	function automatic logic [31:0] lcf_strobe_mask(input logic [3:0] strb);
		return {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
	endfunction : lcf_strobe_mask
endpackage : lcf_pkg

//--- src/lcf_cycle_timer.sv
// cycle timer offset counter with its 24.576 MHz tick generator
`timescale 1ns/10ps
`default_nettype none
module lcf_cycle_timer (
	input wire logic clk_sys_in,
	input wire logic srst_in,
	input wire lcf_pkg::lcf_timer_ctl_type ctl_in,
	input wire logic external_cycle_input_in,
	output lcf_pkg::lcf_timer_stat_type stat_out
);
	import lcf_pkg::*;

	lcf_timer_state_type st_ff;
	lcf_timer_state_type nxt_st;
	logic [15:0] nco_sum;
	logic tick;
	logic ext_event;

	// fractional divider: 3072/25000 of the system clock, jitter of one clock per tick
	always_comb begin
		nxt_st = st_ff;
		nxt_st.rollover = 1'b0;
		nxt_st.ext_prev = external_cycle_input_in;
		ext_event = external_cycle_input_in && !st_ff.ext_prev;
		nco_sum = {1'b0, st_ff.nco} + NCO_STEP;
		tick = nco_sum >= NCO_MOD;
		nxt_st.nco = tick ? 15'(nco_sum - NCO_MOD) : nco_sum[14:0];
		if (ctl_in.run) begin // RULE_10 RULE_11
			if (ctl_in.resync) begin
				nxt_st.offset = 12'h000; // RULE_07
			end else if (ctl_in.ext_select) begin
				if (ext_event) begin
					nxt_st.offset = 12'h000; // RULE_04
					nxt_st.rollover = 1'b1;
				end else if (tick && st_ff.offset != OFFSET_MAX) begin
					// saturates if the external cycle never comes
					nxt_st.offset = st_ff.offset + 12'h001;
				end
			end else if (tick) begin
				if (st_ff.offset == OFFSET_LAST) begin
					nxt_st.offset = 12'h000; // RULE_05
					nxt_st.rollover = 1'b1;
				end else begin
					nxt_st.offset = st_ff.offset + 12'h001; // RULE_10
				end
			end
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			st_ff <= TIMER_RESET;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign stat_out = '{st_ff.rollover, st_ff.offset};

	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (srst_in);

	a_offset_hold: assert property (!ctl_in.run |=> $stable(st_ff.offset)) // RULE_11
		else $error("offset moved while run clear");
	a_internal_roll: assert property (ctl_in.run && !ctl_in.resync && !ctl_in.ext_select && tick // RULE_05
		&& st_ff.offset == OFFSET_LAST |=> st_ff.offset == 12'h000 && st_ff.rollover)
		else $error("internal rollover missed");
	a_offset_step: assert property (ctl_in.run && !ctl_in.resync && !ctl_in.ext_select && tick // RULE_10
		&& st_ff.offset < OFFSET_LAST |=> st_ff.offset == $past(st_ff.offset) + 12'h001)
		else $error("offset did not advance on tick");
	a_external_roll: assert property (ctl_in.run && !ctl_in.resync && ctl_in.ext_select // RULE_04
		&& ext_event |=> st_ff.offset == 12'h000 && st_ff.rollover)
		else $error("external rollover missed");
	a_no_internal_ext: assert property (ctl_in.ext_select && !ext_event |=> !st_ff.rollover) // RULE_04
		else $error("rollover without external event");
	a_resync_zero: assert property (ctl_in.run && ctl_in.resync |=> st_ff.offset == 12'h000) // RULE_07
		else $error("resync did not clear offset");
	c_internal_roll: cover property (st_ff.rollover && !ctl_in.ext_select);
endmodule : lcf_cycle_timer
`default_nettype wire

//--- src/lcf_link_flags.sv
// link core control flag bank with AXI4-Lite slave and cycle timer
`timescale 1ns/10ps
`default_nettype none
module lcf_link_flags (
	input wire logic clk_sys_in,
	input wire logic srst_in,
	input wire logic [7:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic [7:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	input wire logic external_cycle_input_in,
	input wire logic phy_bus_reset_in,
	input wire logic phy_root_in,
	input wire logic overlong_cycle_event_in,
	input wire logic rx_cycle_start_in,
	input wire logic async_receive_request_context_in,
	output logic cycle_start_out,
	output logic [11:0] cycle_offset_out,
	output logic cycle_rollover_out,
	output logic accept_phy_packets_out,
	output logic accept_selfid_packets_out,
	output logic root_status_out
);
	import lcf_pkg::*;

	lcf_bank_state_type st_ff;
	lcf_bank_state_type nxt_st;
	lcf_timer_ctl_type timer_ctl;
	lcf_timer_stat_type timer_stat;
	lcf_sel_type wr_sel;
	lcf_sel_type rd_sel;
	logic wr_fire;
	logic rd_fire;
	logic [31:0] wr_mask;
	logic [31:0] nxt_flags;

	always_comb begin
		nxt_st = st_ff;
		wr_fire = 1'b0;
		wr_sel = SEL_NONE;
		wr_mask = 32'h0000_0000;
		rd_fire = 1'b0;
		rd_sel = lcf_decode(s_axi_araddr_in);
		nxt_flags = st_ff.flags;

		// address and data are taken independently, in either order
		if (st_ff.awready && s_axi_awvalid_in) begin
			nxt_st.aw_got = 1'b1;
			nxt_st.awaddr = s_axi_awaddr_in;
		end
		if (st_ff.wready && s_axi_wvalid_in) begin
			nxt_st.w_got = 1'b1;
			nxt_st.wdata = s_axi_wdata_in;
			nxt_st.wstrb = s_axi_wstrb_in;
		end

		case (st_ff.wst)
			WR_IDLE: begin
				if (nxt_st.aw_got && nxt_st.w_got) begin
					wr_fire = 1'b1;
					wr_sel = lcf_decode(nxt_st.awaddr); // RULE_02
					wr_mask = nxt_st.wdata & lcf_strobe_mask(nxt_st.wstrb) & FLAG_MASK;
					nxt_st.bvalid = 1'b1;
					if (wr_sel == SEL_SET || wr_sel == SEL_CLR) begin
						nxt_st.bresp = RESP_OKAY;
					end else begin
						nxt_st.bresp = RESP_SLVERR;
					end
					nxt_st.wst = WR_RESP;
				end
			end
			WR_RESP: begin
				if (s_axi_bready_in) begin
					nxt_st.bvalid = 1'b0;
					nxt_st.aw_got = 1'b0;
					nxt_st.w_got = 1'b0;
					nxt_st.wst = WR_IDLE;
				end
			end
			default: begin
				nxt_st.wst = WR_IDLE;
			end
		endcase
		nxt_st.awready = (nxt_st.wst == WR_IDLE) && !nxt_st.aw_got;
		nxt_st.wready = (nxt_st.wst == WR_IDLE) && !nxt_st.w_got;

		// set and clear ports act on the one flag word
		if (wr_fire && wr_sel == SEL_SET) begin
			nxt_flags = nxt_flags | wr_mask; // RULE_03
		end
		if (wr_fire && wr_sel == SEL_CLR) begin
			nxt_flags = nxt_flags & ~wr_mask; // RULE_03
		end
		// level of the event both clears the enable and blocks any set
		if (overlong_cycle_event_in) begin
			nxt_flags[ORIGINATOR_BIT] = 1'b0; // RULE_08 RULE_09
		end
		nxt_st.flags = nxt_flags & FLAG_MASK; // RULE_01

		case (st_ff.rst)
			RD_IDLE: begin
				if (st_ff.arready && s_axi_arvalid_in) begin
					rd_fire = 1'b1;
					nxt_st.rvalid = 1'b1;
					nxt_st.rst = RD_DATA;
					nxt_st.rresp = RESP_OKAY;
					if (rd_sel == SEL_SET || rd_sel == SEL_CLR) begin
						nxt_st.rdata = st_ff.flags & FLAG_MASK; // RULE_02 RULE_01
					end else if (rd_sel == SEL_STAT) begin
						nxt_st.rdata = 32'h0000_0000;
						nxt_st.rdata[STAT_ROOT_BIT] = st_ff.root;
						nxt_st.rdata[STAT_OVERLONG_BIT] = overlong_cycle_event_in;
						nxt_st.rdata[11:0] = timer_stat.offset;
					end else begin
						nxt_st.rdata = 32'h0000_0000;
						nxt_st.rresp = RESP_SLVERR;
					end
				end
			end
			RD_DATA: begin
				if (s_axi_rready_in) begin
					nxt_st.rvalid = 1'b0;
					nxt_st.rst = RD_IDLE;
				end
			end
			default: begin
				nxt_st.rst = RD_IDLE;
			end
		endcase
		nxt_st.arready = nxt_st.rst == RD_IDLE;

		// root is only sampled while the phy holds bus reset
		if (phy_bus_reset_in) begin
			nxt_st.root = phy_root_in; // RULE_16
		end
		nxt_st.cycle_start = timer_stat.rollover && st_ff.flags[ORIGINATOR_BIT]
			&& st_ff.root; // RULE_06
		nxt_st.phy_accept = st_ff.flags[PHY_PKT_BIT]
			&& async_receive_request_context_in; // RULE_12
		nxt_st.selfid_accept = st_ff.flags[SELFID_BIT]; // RULE_14 RULE_13
	end

	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			st_ff <= BANK_RESET;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// received cycle starts only steer the timer when this node is not the originator
	always_comb begin
		timer_ctl.run = st_ff.flags[RUN_BIT]; // RULE_10 RULE_11
		timer_ctl.ext_select = st_ff.flags[ORIGIN_SEL_BIT]; // RULE_04 RULE_05
		timer_ctl.resync = rx_cycle_start_in && !st_ff.flags[ORIGINATOR_BIT]; // RULE_07
	end

	lcf_cycle_timer u_timer (
		.clk_sys_in(clk_sys_in),
		.srst_in(srst_in),
		.ctl_in(timer_ctl),
		.external_cycle_input_in(external_cycle_input_in),
		.stat_out(timer_stat)
	);

	assign s_axi_awready_out = st_ff.awready;
	assign s_axi_wready_out = st_ff.wready;
	assign s_axi_bresp_out = st_ff.bresp;
	assign s_axi_bvalid_out = st_ff.bvalid;
	assign s_axi_arready_out = st_ff.arready;
	assign s_axi_rdata_out = st_ff.rdata;
	assign s_axi_rresp_out = st_ff.rresp;
	assign s_axi_rvalid_out = st_ff.rvalid;
	assign cycle_start_out = st_ff.cycle_start;
	assign cycle_offset_out = timer_stat.offset;
	assign cycle_rollover_out = timer_stat.rollover;
	assign accept_phy_packets_out = st_ff.phy_accept;
	assign accept_selfid_packets_out = st_ff.selfid_accept;
	assign root_status_out = st_ff.root;

	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (srst_in);

	a_reserved_zero: assert property ((st_ff.flags & ~FLAG_MASK) == 32'h0000_0000) // RULE_01
		else $error("reserved flag bit set");
	a_read_flags: assert property (rd_fire && (rd_sel == SEL_SET || rd_sel == SEL_CLR) // RULE_02
		|=> s_axi_rvalid_out && s_axi_rdata_out == $past(st_ff.flags)
		&& s_axi_rresp_out == RESP_OKAY)
		else $error("flag read returned wrong word");
	a_set_write: assert property (wr_fire && wr_sel == SEL_SET && !overlong_cycle_event_in // RULE_03
		|=> (st_ff.flags & $past(wr_mask)) == $past(wr_mask))
		else $error("set write lost a flag");
	a_clear_write: assert property (wr_fire && wr_sel == SEL_CLR // RULE_03
		|=> (st_ff.flags & $past(wr_mask)) == 32'h0000_0000)
		else $error("clear write left a flag");
	a_write_resp: assert property (wr_fire |=> s_axi_bvalid_out && !s_axi_awready_out // RULE_02
		&& !s_axi_wready_out)
		else $error("write response missing");
	a_overlong_clear: assert property (overlong_cycle_event_in // RULE_08
		|=> !st_ff.flags[ORIGINATOR_BIT])
		else $error("originator enable not cleared");
	a_overlong_block: assert property (overlong_cycle_event_in && wr_fire && wr_sel == SEL_SET // RULE_09
		|=> !st_ff.flags[ORIGINATOR_BIT])
		else $error("originator set accepted during overlong event");
	a_cycle_start: assert property (timer_stat.rollover && st_ff.flags[ORIGINATOR_BIT] // RULE_06
		&& st_ff.root |=> cycle_start_out)
		else $error("cycle start not emitted");
	a_no_start_slave: assert property (!st_ff.flags[ORIGINATOR_BIT] |=> !cycle_start_out) // RULE_07
		else $error("cycle start while not originator");
	a_phy_gate: assert property (accept_phy_packets_out == $past(st_ff.flags[PHY_PKT_BIT] // RULE_12
		&& async_receive_request_context_in))
		else $error("phy packet gate wrong");
	a_selfid_gate: assert property (##1 accept_selfid_packets_out // RULE_14 RULE_13
		== $past(st_ff.flags[SELFID_BIT]))
		else $error("self-id gate wrong");
	a_root_capture: assert property (phy_bus_reset_in |=> root_status_out == $past(phy_root_in)) // RULE_16
		else $error("root status not recorded");

	c_set_write: cover property (wr_fire && wr_sel == SEL_SET);
	c_cycle_start: cover property (cycle_start_out);
	c_overlong: cover property (st_ff.flags[ORIGINATOR_BIT] ##1 overlong_cycle_event_in);
	c_read_stat: cover property (rd_fire && rd_sel == SEL_STAT);
endmodule : lcf_link_flags
`default_nettype wire

//--- verification/lcf_phy_model.sv
// behavioural phy and bus-node model driving the link-side inputs of the flag bank
`timescale 1ns/10ps
`default_nettype none
module lcf_phy_model (
	input wire logic clk_sys_in,
	output logic bus_reset_out,
	output logic root_out,
	output logic overlong_out,
	output logic rx_cycle_start_out,
	output logic ext_cycle_out
);
	initial begin
		bus_reset_out = 1'b0;
		root_out = 1'b0;
		overlong_out = 1'b0;
		rx_cycle_start_out = 1'b0;
		ext_cycle_out = 1'b0;
	end

	// root is reported only while bus reset runs; the level is kept afterwards
	task automatic bus_reset(input logic is_root);
		bus_reset_out <= 1'b1;
		root_out <= is_root;
		repeat (4) @(posedge clk_sys_in);
		bus_reset_out <= 1'b0;
	endtask : bus_reset

	// a received cycle start packet is a one-cycle pulse
	task automatic cycle_start_pkt();
		rx_cycle_start_out <= 1'b1;
		@(posedge clk_sys_in);
		rx_cycle_start_out <= 1'b0;
	endtask : cycle_start_pkt

	task automatic set_overlong(input logic v);
		overlong_out <= v;
	endtask : set_overlong

	// only the rising edge matters, so the caller chooses when to drop it
	task automatic set_ext(input logic v);
		ext_cycle_out <= v;
	endtask : set_ext
endmodule : lcf_phy_model
`default_nettype wire

//--- verification/tb.sv
// self-checking bench of the link core control flag bank
`timescale 1ns/10ps
`default_nettype none
module tb;
	import lcf_pkg::*;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic [7:0] awaddr = 8'h00;
	logic awvalid = 1'b0;
	logic [31:0] wdata = 32'h0000_0000;
	logic [3:0] wstrb = 4'h0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic [7:0] araddr = 8'h00;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic ctx = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic br, root, ovl, rxcs, ext;
	logic cstart, roll, phy_ok, sid_ok, root_st;
	logic [11:0] offset;
	logic [11:0] held;
	int error_cnt = 0;
	int check_count = 0;
	int tmo = 0;
	int n;

	always #2.5 clk = ~clk;

	lcf_phy_model phy (.clk_sys_in(clk), .bus_reset_out(br), .root_out(root),
		.overlong_out(ovl), .rx_cycle_start_out(rxcs), .ext_cycle_out(ext));

	lcf_link_flags dut (.clk_sys_in(clk), .srst_in(srst), .s_axi_awaddr_in(awaddr),
		.s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
		.s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
		.s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
		.s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
		.s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
		.s_axi_rready_in(rready), .external_cycle_input_in(ext), .phy_bus_reset_in(br),
		.phy_root_in(root), .overlong_cycle_event_in(ovl), .rx_cycle_start_in(rxcs),
		.async_receive_request_context_in(ctx), .cycle_start_out(cstart),
		.cycle_offset_out(offset), .cycle_rollover_out(roll),
		.accept_phy_packets_out(phy_ok), .accept_selfid_packets_out(sid_ok),
		.root_status_out(root_st));

	task automatic summarize();
		if (error_cnt == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : summarize

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : chk

	// entered just after a rising edge; address and data are offered together
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] er);
		logic ad;
		logic wd;
		ad = 1'b0;
		wd = 1'b0;
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awvalid && awready) begin
				ad = 1'b1;
				awvalid <= 1'b0;
			end
			if (wvalid && wready) begin
				wd = 1'b1;
				wvalid <= 1'b0;
			end
		end while (!(ad && wd));
		do @(posedge clk); while (bvalid !== 1'b1);
		bready <= 1'b0;
		chk({30'h0, bresp}, {30'h0, er});
		// one idle edge so a following call never re-raises bready in the same step
		@(posedge clk);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge clk); while (rvalid !== 1'b1);
		rready <= 1'b0;
		chk(rdata, ed);
		chk({30'h0, rresp}, {30'h0, er});
		@(posedge clk);
	endtask : rd

	// counts edges until the rollover pulse is seen
	task automatic wait_roll(output int cnt);
		cnt = 0;
		do begin
			@(posedge clk);
			cnt++;
		end while (roll !== 1'b1);
	endtask : wait_roll

	always @(posedge clk) begin
		tmo++;
		if (tmo == 80000) begin
			error_cnt++;
			summarize();
		end
	end

	initial begin
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		rd(SET_OFFSET, FLAG_RESET, RESP_OKAY);
		rd(CLR_OFFSET, FLAG_RESET, RESP_OKAY);
		// the self-id buffer pointer lives outside this block and counts as loaded here
		wr(SET_OFFSET, 32'hFFFF_FFFF, 4'hF, RESP_OKAY);
		rd(SET_OFFSET, 32'h0070_0600, RESP_OKAY);
		rd(CLR_OFFSET, 32'h0070_0600, RESP_OKAY);
		chk({31'h0, phy_ok}, 32'h0);
		ctx <= 1'b1;
		repeat (3) @(posedge clk);
		chk({31'h0, phy_ok}, 32'h1);
		chk({31'h0, sid_ok}, 32'h1);
		wr(CLR_OFFSET, 32'h0000_0400, 4'hF, RESP_OKAY);
		repeat (2) @(posedge clk);
		chk({31'h0, phy_ok}, 32'h0);
		chk({31'h0, sid_ok}, 32'h1);
		// only byte lane 1 is enabled, so the timer flags must survive
		wr(CLR_OFFSET, 32'hFFFF_FFFF, 4'h2, RESP_OKAY);
		rd(SET_OFFSET, 32'h0070_0000, RESP_OKAY);
		wr(8'h10, 32'hFFFF_FFFF, 4'hF, RESP_SLVERR);
		rd(8'h10, 32'h0000_0000, RESP_SLVERR);
		rd(CLR_OFFSET, 32'h0070_0000, RESP_OKAY);
		wr(CLR_OFFSET, 32'h0050_0000, 4'hF, RESP_OKAY);
		repeat (2) @(posedge clk);
		held = offset;
		repeat (40) @(posedge clk);
		chk({20'h0, offset}, {20'h0, held});
		wr(SET_OFFSET, 32'h0010_0000, 4'hF, RESP_OKAY);
		repeat (2) @(posedge clk);
		held = offset;
		repeat (20) @(posedge clk);
		chk({31'h0, offset !== held}, 32'h1);
		wr(CLR_OFFSET, 32'h0020_0000, 4'hF, RESP_OKAY);
		repeat (40) @(posedge clk);
		phy.cycle_start_pkt();
		@(posedge clk);
		chk({31'h0, offset < 12'h002}, 32'h1);
		phy.bus_reset(1'b1);
		repeat (2) @(posedge clk);
		chk({31'h0, root_st}, 32'h1);
		wr(SET_OFFSET, 32'h0020_0000, 4'hF, RESP_OKAY);
		wait_roll(n);
		chk({20'h0, offset}, 32'h0);
		@(posedge clk);
		chk({31'h0, cstart}, 32'h1);
		wait_roll(n);
		chk(n, 24999);
		phy.set_overlong(1'b1);
		repeat (3) @(posedge clk);
		rd(SET_OFFSET, 32'h0010_0000, RESP_OKAY);
		wr(SET_OFFSET, 32'h0020_0000, 4'hF, RESP_OKAY);
		rd(SET_OFFSET, 32'h0010_0000, RESP_OKAY);
		phy.set_overlong(1'b0);
		repeat (2) @(posedge clk);
		wr(SET_OFFSET, 32'h0060_0000, 4'hF, RESP_OKAY);
		rd(SET_OFFSET, 32'h0070_0000, RESP_OKAY);
		repeat (30) @(posedge clk);
		phy.set_ext(1'b1);
		wait_roll(n);
		chk({31'h0, n < 6}, 32'h1);
		@(posedge clk);
		chk({31'h0, cstart}, 32'h1);
		phy.set_ext(1'b0);
		summarize();
	end
endmodule : tb
`default_nettype wire
